// File: stp_cond.v
// Bus condition and clock edge detector for the target port.
`timescale 1ns/1ps
module stp_cond (
   // Clock and reset
   input  wire ref_clk,
   input  wire rst,
   // Synchronised bus lines
   input  wire scl_s,
   input  wire sda_s,
   // Events, one cycle each
   output reg  scl_rise_r,
   output reg  scl_fall_r,
   output reg  start_r,
   output reg  stop_r
);
   reg scl_d_r;
   reg sda_d_r;
   // Set while the present clock-high interval saw a START.
   reg start_hi_r;

   always @(posedge ref_clk) begin
      if (rst) begin
         scl_d_r    <= 1'b1;
         sda_d_r    <= 1'b1;
         scl_rise_r <= 1'b0;
         scl_fall_r <= 1'b0;
         start_r    <= 1'b0;
         stop_r     <= 1'b0;
         start_hi_r <= 1'b0;
      end else begin
         scl_d_r    <= scl_s;
         sda_d_r    <= sda_s;
         scl_rise_r <= scl_s & ~scl_d_r;
         scl_fall_r <= ~scl_s & scl_d_r;
         start_r    <= scl_s & scl_d_r & sda_d_r & ~sda_s;
         // A STOP in the same high pulse as its START is ignored.
         stop_r     <= scl_s & scl_d_r & ~sda_d_r & sda_s & ~start_hi_r;
         if (~scl_s)
            start_hi_r <= 1'b0;
         else if (scl_d_r & sda_d_r & ~sda_s)
            start_hi_r <= 1'b1;
      end
   end
endmodule

// File: stp_host.sv
// Behavioural two-wire bus controller that clocks the bus and pulls the data line.
`timescale 1ns/1ps
module stp_host (
   // Pacing clock
   input        ref_clk,
   // Bus lines
   input        sda,
   output logic scl,
   output logic pull
);
   initial begin
      scl = 1'h1;
      pull = 1'h0;
   end
   task automatic hw(input int n);
      repeat (n) @(posedge ref_clk);
      #2;
   endtask
   // Data moves two clocks after the fall so both synchronisers see the fall first.
   // Fifty clocks a bit keep data bits at the 400kHz ceiling; start and stop pulses run shorter.
   task automatic bit_io(input logic b, output logic r);
      hw(2);
      pull = !b;
      hw(23);
      scl = 1'h1;
      hw(12);
      r = sda;
      hw(13);
      scl = 1'h0;
   endtask
   task automatic start();
      hw(2);
      pull = 1'h0;
      hw(8);
      scl = 1'h1;
      hw(8);
      pull = 1'h1;
      hw(8);
      scl = 1'h0;
   endtask
   task automatic stop();
      hw(2);
      pull = 1'h1;
      hw(6);
      scl = 1'h1;
      hw(8);
      pull = 1'h0;
      hw(8);
   endtask
   task automatic bits(input logic [7:0] d, input int n);
      logic r;
      for (int i = 7; i > 7 - n; i--) bit_io(d[i], r);
   endtask
   task automatic tx(input logic [7:0] d, output logic ack);
      logic r;
      bits(d, 8);
      bit_io(1'h1, r);
      ack = !r;
   endtask
   task automatic rx(input logic ack, output logic [7:0] d);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bit_io(1'h1, r);
         d[i] = r;
      end
      bit_io(!ack, r);
   endtask
endmodule

// File: stp_regs.vh
// Constants for the two-wire sensor target port.
`ifndef STP_REGS_VH
`define STP_REGS_VH
`define STP_ADDR_GND     7'h5A
`define STP_ADDR_VCC     7'h5B
`define STP_BITS_BYTE    4'h8
`define STP_SCL_MAX_KHZ  400
`define STP_CLK_MHZ      20
`define STP_SCL_MIN_CYC  (`STP_CLK_MHZ * 1000 / `STP_SCL_MAX_KHZ)
`define STP_ST_IDLE      3'h0
`define STP_ST_ADDR      3'h1
`define STP_ST_PTR       3'h2
`define STP_ST_WDATA     3'h3
`define STP_ST_RDATA     3'h4
`endif

// File: stp_sync.v
// Two-flop synchroniser for one bus pin.
`timescale 1ns/1ps
module stp_sync (
   // Clock and reset
   input  wire ref_clk,
   input  wire rst,
   // Pin and result
   input  wire din,
   output reg  dout_r
);
   reg meta_r;

   always @(posedge ref_clk) begin
      if (rst) begin
         meta_r <= 1'b1;
         dout_r <= 1'b1;
      end else begin
         meta_r <= din;
         dout_r <= meta_r;
      end
   end
endmodule

// File: stp_target.v
// Two-wire target port: address match, pointer, register writes and reads.
`timescale 1ns/1ps
`include "stp_regs.vh"
module stp_target (
   // Clock and reset
   input  wire       ref_clk,
   input  wire       rst,
   // Bus pins; serial clock is input only
   input  wire       scl_in,
   input  wire       sda_in,
   output reg        sda_out_r,
   output reg        sda_oe_r,
   // Address strap, static
   input  wire       address_select_pin,
   // Register side
   output reg  [7:0] reg_ptr_r,
   output reg  [7:0] reg_wdata_r,
   output reg        reg_wr_r,
   output reg        reg_rd_r,
   input  wire [7:0] reg_rdata,
   // Status
   output reg        busy_r
);
   wire scl_s;
   wire sda_s;
   wire sel_s;
   wire scl_rise;
   wire scl_fall;
   wire start_ev;
   wire stop_ev;

   // Pins pass two flops before use; serial clock is sampled, never driven.
   stp_sync u_scl (
      .ref_clk (ref_clk),
      .rst     (rst),
      .din     (scl_in),
      .dout_r  (scl_s)
   );
   stp_sync u_sda (
      .ref_clk (ref_clk),
      .rst     (rst),
      .din     (sda_in),
      .dout_r  (sda_s)
   );
   stp_sync u_sel (
      .ref_clk (ref_clk),
      .rst     (rst),
      .din     (address_select_pin),
      .dout_r  (sel_s)
   );
   // 20 MHz sampling gives 50 cycles per 400kHz period, ample margin.
   stp_cond u_cond (
      .ref_clk    (ref_clk),
      .rst        (rst),
      .scl_s      (scl_s),
      .sda_s      (sda_s),
      .scl_rise_r (scl_rise),
      .scl_fall_r (scl_fall),
      .start_r    (start_ev),
      .stop_r     (stop_ev)
   );

   // True when the upper seven bits name this target.
   function addr_match;
      input [6:0] a;
      input       sel;
      begin
         addr_match = (a == (sel ? `STP_ADDR_VCC : `STP_ADDR_GND));
      end
   endfunction

   reg [2:0] state_r;
   reg [3:0] bit_cnt_r;
   reg [7:0] shift_r;
   reg [7:0] tx_r;
   reg       ack_slot_r;
   reg       ack_drive_r;
   reg       got_byte_r;
   reg [7:0] rx_byte_r;

   wire [7:0] rx_nxt = {shift_r[6:0], sda_s};

   always @(posedge ref_clk) begin
      if (rst) begin
         state_r     <= `STP_ST_IDLE;
         bit_cnt_r   <= 4'h0;
         shift_r     <= 8'h00;
         tx_r        <= 8'hFF;
         ack_slot_r  <= 1'b0;
         ack_drive_r <= 1'b0;
         got_byte_r  <= 1'b0;
         rx_byte_r   <= 8'h00;
         sda_out_r   <= 1'b0;
         sda_oe_r    <= 1'b0;
         reg_ptr_r   <= 8'h00;
         reg_wdata_r <= 8'h00;
         reg_wr_r    <= 1'b0;
         reg_rd_r    <= 1'b0;
         busy_r      <= 1'b0;
      end else begin
         reg_wr_r   <= 1'b0;
         reg_rd_r   <= 1'b0;
         got_byte_r <= 1'b0;
         sda_out_r  <= 1'b0;
         // The store must see the pointer that selected the byte, so it moves a cycle later.
         if (reg_wr_r)
            reg_ptr_r <= reg_ptr_r + 8'h01;
         if (start_ev) begin
            // Partial byte is dropped; a new address byte follows.
            state_r     <= `STP_ST_ADDR;
            bit_cnt_r   <= 4'h0;
            ack_slot_r  <= 1'b0;
            ack_drive_r <= 1'b0;
            sda_oe_r    <= 1'b0;
            busy_r      <= 1'b1;
         end else if (stop_ev) begin
            state_r     <= `STP_ST_IDLE;
            bit_cnt_r   <= 4'h0;
            ack_slot_r  <= 1'b0;
            ack_drive_r <= 1'b0;
            sda_oe_r    <= 1'b0;
            busy_r      <= 1'b0;
         end else if (state_r != `STP_ST_IDLE) begin
            if (scl_rise && !ack_slot_r && state_r != `STP_ST_RDATA) begin
               // Sample one bit per high pulse, where it is stable.
               shift_r   <= rx_nxt;
               bit_cnt_r <= bit_cnt_r + 4'h1;
               if (bit_cnt_r == `STP_BITS_BYTE - 4'h1) begin
                  got_byte_r <= 1'b1;
                  rx_byte_r  <= rx_nxt;
               end
            end else if (scl_rise && !ack_slot_r) begin
               bit_cnt_r <= bit_cnt_r + 4'h1;
            end else if (scl_rise && ack_slot_r && state_r == `STP_ST_RDATA) begin
               // Controller answers; a high level ends the read.
               if (sda_s)
                  state_r <= `STP_ST_IDLE;
            end
            if (got_byte_r) begin
               case (state_r)
                  `STP_ST_ADDR: begin
                     if (addr_match(rx_byte_r[7:1], sel_s)) begin
                        ack_drive_r <= 1'b1;
                        if (rx_byte_r[0]) begin
                           state_r  <= `STP_ST_RDATA;
                           reg_rd_r <= 1'b1;
                        end else begin
                           state_r  <= `STP_ST_PTR;
                        end
                     end else begin
                        state_r <= `STP_ST_IDLE;
                     end
                  end
                  `STP_ST_PTR: begin
                     reg_ptr_r   <= rx_byte_r;
                     ack_drive_r <= 1'b1;
                     state_r     <= `STP_ST_WDATA;
                  end
                  `STP_ST_WDATA: begin
                     reg_wdata_r <= rx_byte_r;
                     reg_wr_r    <= 1'b1;
                     ack_drive_r <= 1'b1;
                  end
                  default: begin
                     ack_drive_r <= 1'b0;
                  end
               endcase
            end
            if (reg_rd_r)
               tx_r <= reg_rdata;
            if (scl_fall) begin
               if (!ack_slot_r && bit_cnt_r == `STP_BITS_BYTE) begin
                  // Ninth pulse starts here; hold low through it.
                  ack_slot_r <= 1'b1;
                  bit_cnt_r  <= 4'h0;
                  // Only received bytes arm ack_drive_r; after a sent byte it is clear,
                  // so the controller owns that slot.
                  sda_oe_r   <= ack_drive_r;
               end else if (ack_slot_r) begin
                  ack_slot_r  <= 1'b0;
                  ack_drive_r <= 1'b0;
                  if (state_r == `STP_ST_RDATA) begin
                     // Drive the first bit before the next rising edge.
                     sda_oe_r <= ~tx_r[7];
                     tx_r     <= {tx_r[6:0], 1'b1};
                  end else begin
                     sda_oe_r <= 1'b0;
                  end
               end else if (state_r == `STP_ST_RDATA) begin
                  sda_oe_r <= ~tx_r[7];
                  tx_r     <= {tx_r[6:0], 1'b1};
               end else begin
                  sda_oe_r <= 1'b0;
               end
            end
         end else begin
            sda_oe_r <= 1'b0;
         end
      end
   end
endmodule

// File: stp_target_sva.sv
// Concurrent checks on the target port pins, status and register strobes.
`timescale 1ns/1ps
module stp_target_sva (
   // Clock, reset and bus pins
   input       ref_clk,
   input       rst,
   input       scl_in,
   input       sda_in,
   input       sda_out_r,
   input       sda_oe_r,
   input       address_select_pin,
   // Register side and status
   input [7:0] reg_ptr_r,
   input [7:0] reg_wdata_r,
   input       reg_wr_r,
   input       reg_rd_r,
   input [7:0] reg_rdata,
   input       busy_r
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);
   property p_od; !sda_out_r; endproperty
   a_od: assert property (p_od) else $error("data driven high");
   property p_idle; !busy_r |-> !sda_oe_r; endproperty
   a_idle: assert property (p_idle) else $error("pull while idle");
   property p_start; scl_in && $fell(sda_in) |-> ##[2:8] busy_r; endproperty
   a_start: assert property (p_start) else $error("start missed");
   property p_stop; scl_in && $rose(sda_in) |-> ##[2:8] !busy_r; endproperty
   a_stop: assert property (p_stop) else $error("stop missed");
   property p_ofall; $fell(sda_oe_r) |-> !scl_in; endproperty
   a_ofall: assert property (p_ofall) else $error("release in high");
   property p_orise; $rose(sda_oe_r) |-> !scl_in; endproperty
   a_orise: assert property (p_orise) else $error("pull in high");
   property p_wr; reg_wr_r |=> !reg_wr_r && reg_ptr_r == $past(reg_ptr_r) + 8'h01; endproperty
   a_wr: assert property (p_wr) else $error("bad write strobe");
   property p_rd; reg_rd_r |-> busy_r ##[0:30] sda_oe_r; endproperty
   a_rd: assert property (p_rd) else $error("read not acked");
endmodule

// File: stp_target_tb_top.sv
// Self-checking bench for the two-wire target port.
`timescale 1ns/1ps
module stp_target_tb_top;
   logic        ref_clk, rst, sel, scl, pull, oe, dout, wr, rd, busy;
   logic [7:0]  ptr, wdata, p, d0, d1, q;
   logic [7:0]  mem [256];
   logic [31:0] seed;
   int          err_total, n_tests, n_wr, cyc, w;
   wire         sda_w = (oe ? dout : 1'h1) & ~pull;
   wire  [7:0]  rdata = mem[ptr];
   stp_host u_stp_host (.ref_clk(ref_clk), .sda(sda_w), .scl(scl), .pull(pull));
   stp_target u_stp_target (.ref_clk(ref_clk), .rst(rst), .scl_in(scl), .sda_in(sda_w),
      .sda_out_r(dout), .sda_oe_r(oe), .address_select_pin(sel), .reg_ptr_r(ptr),
      .reg_wdata_r(wdata), .reg_wr_r(wr), .reg_rd_r(rd), .reg_rdata(rdata), .busy_r(busy));
   initial begin
      ref_clk = 1'h0;
      forever #25 ref_clk = ~ref_clk;
   end
   function automatic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   function automatic [7:0] adr(input logic s, input logic r);
      return {6'h2D, s, r};
   endfunction
   task automatic conclude();
      $display("comparisons %0d mismatches %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] s);
      n_tests++;
      if (s !== e) begin
         err_total++;
         $display("unexpected %s expected %h seen %h", nm, e, s);
      end
   endtask
   task automatic send(input logic [7:0] d, input logic a);
      logic k;
      u_stp_host.tx(d, k);
      chk("ack", {7'h00, a}, {7'h00, k});
   endtask
   // The bench plays the register store, so written bytes land in mem.
   always @(posedge ref_clk) begin
      cyc <= cyc + 1;
      if (wr) begin
         mem[ptr] <= wdata;
         n_wr <= n_wr + 1;
      end
      if (cyc == 60000) begin
         err_total++;
         conclude();
      end
   end
   initial begin
      {rst, sel, seed, err_total, n_tests, n_wr, cyc} = {1'h1, 1'h0, 32'h0000_6194, 128'h0};
      repeat (16) @(posedge ref_clk);
      #2 rst = 1'h0;
      repeat (8) @(posedge ref_clk);
      for (int k = 0; k < 6; k++) begin
         p = 8'(xs());
         d0 = (k == 0) ? 8'h00 : (k == 1) ? 8'hFF : 8'(xs());
         d1 = 8'(xs());
         sel = k[0];
         u_stp_host.start();
         chk("busy", 8'h01, {7'h00, busy});
         send(adr(sel, 1'h0), 1'h1);
         send(p, 1'h1);
         send(d0, 1'h1);
         send(d1, 1'h1);
         u_stp_host.stop();
         chk("busy", 8'h00, {7'h00, busy});
         chk("store", d0, mem[p]);
         chk("next", d1, mem[p + 8'h01]);
         u_stp_host.start();
         send(adr(sel, 1'h0), 1'h1);
         send(p, 1'h1);
         u_stp_host.start();
         send(adr(sel, 1'h1), 1'h1);
         u_stp_host.rx(1'h0, q);
         chk("rdata", d0, q);
         u_stp_host.stop();
         w = n_wr;
         u_stp_host.start();
         send(adr(!sel, k[1]), 1'h0);
         send(p, 1'h0);
         u_stp_host.start();
         send(adr(sel, 1'h0), 1'h1);
         send(p, 1'h1);
         u_stp_host.bits(d1, 3);
         u_stp_host.stop();
         chk("busy", 8'h00, {7'h00, busy});
         chk("writes", w[7:0], n_wr[7:0]);
      end
      conclude();
   end
endmodule
bind stp_target stp_target_sva u_sva (.ref_clk, .rst, .scl_in, .sda_in, .sda_out_r, .sda_oe_r,
   .address_select_pin, .reg_ptr_r, .reg_wdata_r, .reg_wr_r, .reg_rd_r, .reg_rdata, .busy_r);
